// ==== shared/rhip_pkg.sv ====
// constants, types and helpers shared by the host serial port block
// assumes one system clock; the i2c lines arrive asynchronously on pins
package rhip_pkg;

	////////////////////////////////////////////////////////////////////////
	// bus addressing and mode byte layout
	localparam logic [6:0] RHIP_BUS_ADDR   = 7'h50;
	localparam logic [7:0] RHIP_BANK_PFX   = 8'hfb;
	localparam logic [7:0] RHIP_DISC_BYTE  = 8'hff;
	localparam logic [5:0] RHIP_DISC_START = 6'h01;
	localparam logic [1:0] RHIP_M_WREG     = 2'h0;
	localparam logic [1:0] RHIP_M_RREG     = 2'h1;
	localparam logic [1:0] RHIP_M_MEM      = 2'h2;
	localparam logic [1:0] RHIP_M_CMD      = 2'h3;
	localparam int         RHIP_MODE_HI    = 7;
	localparam int         RHIP_MODE_LO    = 6;

	// fifo and passive target memory sub-modes
	localparam logic [5:0] RHIP_SUB_FIFO_LD = 6'h00;
	localparam logic [5:0] RHIP_SUB_FIFO_RD = 6'h1f;
	localparam logic [5:0] RHIP_SUB_PTM_A   = 6'h20;
	localparam logic [5:0] RHIP_SUB_PTM_F   = 6'h28;
	localparam logic [5:0] RHIP_SUB_PTM_TSN = 6'h2c;

	// passive target memory region starts
	localparam int         RHIP_PTM_AW      = 7;
	localparam logic [6:0] RHIP_PTM_A_BASE  = 7'h00;
	localparam logic [6:0] RHIP_PTM_F_BASE  = 7'h0f;
	localparam logic [6:0] RHIP_PTM_T_BASE  = 7'h24;

	// direct command codes that matter here
	localparam logic [5:0] RHIP_CMD_TRANSP  = 6'h1c;

	// bit engine
	localparam logic [3:0] RHIP_BYTE_BITS   = 4'h8;

	////////////////////////////////////////////////////////////////////////
	// types
	typedef enum { LK_IDLE, LK_RX, LK_RX_ACK, LK_TX, LK_TX_ACK } rhip_link_t;
	typedef enum { OP_ADDR, OP_MODE, OP_WREG, OP_FIFO, OP_PTM, OP_IGNORE } rhip_op_t;
	typedef enum { RD_NONE, RD_REG, RD_FIFO, RD_DISC } rhip_rd_t;

	// register write carrier
	typedef struct packed {
		logic       bank_b; // secondary bank selected
		logic [5:0] addr;   // register address
		logic [7:0] data;   // byte to store
	} rhip_wr_t;

	// passive target memory write carrier
	typedef struct packed {
		logic [RHIP_PTM_AW-1:0] addr;
		logic [7:0]             data;
	} rhip_ptm_t;

	////////////////////////////////////////////////////////////////////////
	// commands that run for a while and report completion by interrupt
	function automatic logic rhip_cmd_timed(input logic [5:0] code);
		case (code)
			6'h08, 6'h09, 6'h13, 6'h16, 6'h19, 6'h1f, 6'h2a: rhip_cmd_timed = 1'b1;
			default: rhip_cmd_timed = 1'b0;
		endcase
	endfunction

endpackage

// ==== src/rhip_sync.sv ====
// two flip-flop synchroniser for pin inputs
// assumes inputs are asynchronous to clk_sys
`timescale 1ns/1ps
module rhip_sync
	import rhip_pkg::*;
#(
	parameter int W = 3
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_reg; // first stage, read only by second stage
	logic [W-1:0] meta_next;
	logic [W-1:0] sync_reg; // second stage
	logic [W-1:0] sync_next;

	////////////////////////////////////////////////////////////////////////
	// next values; lines idle high so reset to ones
	always_comb begin
		meta_next = meta_reg;
		sync_next = sync_reg;
		if (ce) begin
			meta_next = async_in;
			sync_next = meta_reg;
		end
	end

	// registers only
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_reg <= '1;
			sync_reg <= '1;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg;

endmodule

// ==== src/rhip_cmd_exec.sv ====
// direct command tracker: busy flag and completion event
// assumes front end pulses cmd_done on clk_sys when a timed command ends
`timescale 1ns/1ps
module rhip_cmd_exec
	import rhip_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic       cmd_start,
	input  wire logic [5:0] cmd_code,
	input  wire logic       cmd_done,
	output logic            busy,
	output logic            done_evt
);

	logic busy_reg; // timed command in progress
	logic busy_next;
	logic evt_reg;  // one-cycle completion event
	logic evt_next;

	////////////////////////////////////////////////////////////////////////
	// only timed commands hold busy; immediate ones never raise it
	always_comb begin
		busy_next = busy_reg;
		evt_next  = 1'b0;
		if (ce) begin
			if (busy_reg && cmd_done) begin
				busy_next = 1'b0;
				evt_next  = 1'b1;
			end
			if (cmd_start && rhip_cmd_timed(cmd_code)) begin
				busy_next = 1'b1;
			end
		end else begin
			evt_next = evt_reg;
		end
	end

	// registers only
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			busy_reg <= 1'b0;
			evt_reg  <= 1'b0;
		end else begin
			busy_reg <= busy_next;
			evt_reg  <= evt_next;
		end
	end

	assign busy     = busy_reg;
	assign done_evt = evt_reg;

endmodule

// ==== src/rhip_i2c_port.sv ====
// i2c target port of the reader host interface
// assumes scl, sda and target_select_n come from pins; the register file,
// fifo, passive target memory and front end sit on clk_sys beside it
`timescale 1ns/1ps
module rhip_i2c_port
	import rhip_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        ce,
	// bus pins
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n,
	input  wire logic        target_select_n,
	output logic             irq,
	// register file
	output logic             reg_wr,
	output rhip_wr_t         reg_wr_bus,
	output logic [5:0]       reg_rd_addr,
	output logic             reg_rd_bank_b,
	input  wire logic [7:0]  reg_rd_data,
	input  wire logic        reg_rd_exists,
	// fifo
	output logic             fifo_push,
	output logic [7:0]       fifo_push_data,
	output logic             fifo_pop,
	input  wire logic [7:0]  fifo_rd_data,
	// passive target memory
	output logic             ptm_wr,
	output rhip_ptm_t        ptm_wr_bus,
	// direct commands and front end
	output logic             cmd_strobe,
	output logic [5:0]       cmd_code,
	input  wire logic        cmd_done,
	output logic             cmd_busy,
	output logic             transparent
);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisation and line events
	logic [2:0] pins_s;   // {target_select_n, sda, scl} after two flops
	logic       scl_s;
	logic       sda_s;
	logic       tsel_s;
	logic       scl_q;    // previous synchronised scl
	logic       sda_q;    // previous synchronised sda
	logic       scl_rise;
	logic       scl_fall;
	logic       bus_start;
	logic       bus_stop;
	logic       done_evt;

	rhip_sync #(.W(3)) u_sync (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.ce       (ce),
		.async_in ({target_select_n, sda_in, scl_in}),
		.sync_out (pins_s)
	);

	assign scl_s    = pins_s[0];
	assign sda_s    = pins_s[1];
	assign tsel_s   = pins_s[2];
	// at 50 MHz a high-speed bit still spans over ten samples
	assign scl_rise = scl_s & ~scl_q;
	assign scl_fall = ~scl_s & scl_q;
	assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
	assign bus_stop  = scl_s & scl_q & ~sda_q & sda_s;

	////////////////////////////////////////////////////////////////////////
	// state
	rhip_link_t           lk_reg,    lk_next;     // bit engine phase
	rhip_op_t             op_reg,    op_next;     // meaning of next written byte
	rhip_rd_t             rd_reg,    rd_next;     // source of read bytes
	logic [7:0]           sh_reg,    sh_next;     // shift register
	logic [3:0]           cnt_reg,   cnt_next;    // bits moved in this byte
	logic                 pull_reg,  pull_next;   // pulling sda low
	logic                 rw_reg,    rw_next;     // current transfer is a read
	logic                 mode_reg,  mode_next;   // mode byte seen since stop
	logic                 bank_reg,  bank_next;   // secondary bank selected
	logic [5:0]           wa_reg,    wa_next;     // register write pointer
	logic [5:0]           ra_reg,    ra_next;     // register read pointer
	logic [RHIP_PTM_AW-1:0] pa_reg,  pa_next;     // memory write pointer
	logic                 tp_pend_reg, tp_pend_next; // transparent after ack
	logic                 tp_reg,    tp_next;     // transparent session
	logic                 tp_sel_reg, tp_sel_next; // select seen low in session
	logic                 irq_reg,   irq_next;    // interrupt line
	logic                 scl_q_next, sda_q_next;
	// one-cycle strobes and their data
	logic                 wr_reg,    wr_next;
	rhip_wr_t             wb_reg,    wb_next;
	logic                 push_reg,  push_next;
	logic [7:0]           pd_reg,    pd_next;
	logic                 pop_reg,   pop_next;
	logic                 pw_reg,    pw_next;
	rhip_ptm_t            pb_reg,    pb_next;
	logic                 cs_reg,    cs_next;
	logic [5:0]           cc_reg,    cc_next;

	////////////////////////////////////////////////////////////////////////
	// next values of the whole port
	always_comb begin
		lk_next      = lk_reg;
		op_next      = op_reg;
		rd_next      = rd_reg;
		sh_next      = sh_reg;
		cnt_next     = cnt_reg;
		pull_next    = pull_reg;
		rw_next      = rw_reg;
		mode_next    = mode_reg;
		bank_next    = bank_reg;
		wa_next      = wa_reg;
		ra_next      = ra_reg;
		pa_next      = pa_reg;
		tp_pend_next = tp_pend_reg;
		tp_next      = tp_reg;
		tp_sel_next  = tp_sel_reg;
		irq_next     = irq_reg;
		scl_q_next   = scl_q;
		sda_q_next   = sda_q;
		wr_next      = wr_reg;
		wb_next      = wb_reg;
		push_next    = push_reg;
		pd_next      = pd_reg;
		pop_next     = pop_reg;
		pw_next      = pw_reg;
		pb_next      = pb_reg;
		cs_next      = cs_reg;
		cc_next      = cc_reg;
		if (ce) begin
			scl_q_next = scl_s;
			sda_q_next = sda_s;
			wr_next    = 1'b0;
			push_next  = 1'b0;
			pop_next   = 1'b0;
			pw_next    = 1'b0;
			cs_next    = 1'b0;
			// host resumes with a start; completion set below wins
			if (bus_start && !tp_reg) begin
				irq_next = 1'b0;
			end
			if (done_evt) begin
				irq_next = 1'b1;
			end
			if (tp_reg) begin
				// lines belong to the front end; select low then a clock ends it
				pull_next = 1'b0;
				lk_next   = LK_IDLE;
				if (!tsel_s) begin
					tp_sel_next = 1'b1;
				end
				if (tp_sel_reg && scl_rise) begin
					tp_next     = 1'b0;
					tp_sel_next = 1'b0;
					// a stop during the session was not seen; start clean
					mode_next   = 1'b0;
					bank_next   = 1'b0;
					rd_next     = RD_NONE;
				end
			end else if (bus_stop) begin
				lk_next   = LK_IDLE;
				pull_next = 1'b0;
				bank_next = 1'b0;
				mode_next = 1'b0;
				rd_next   = RD_NONE;
			end else if (bus_start) begin
				lk_next   = LK_RX;
				op_next   = OP_ADDR;
				cnt_next  = '0;
				pull_next = 1'b0;
			end else begin
				case (lk_reg)
					// collect eight bits on rising clock
					LK_RX: begin
						if (scl_rise && cnt_reg != RHIP_BYTE_BITS) begin
							sh_next  = {sh_reg[6:0], sda_s};
							cnt_next = cnt_reg + 4'h1;
						end else if (scl_fall && cnt_reg == RHIP_BYTE_BITS) begin
							pull_next = 1'b1;
							lk_next   = LK_RX_ACK;
							case (op_reg)
								OP_ADDR: begin
									rw_next = sh_reg[0];
									if (sh_reg[7:1] != RHIP_BUS_ADDR) begin
										pull_next = 1'b0;
										lk_next   = LK_IDLE;
									end else if (sh_reg[0] && !mode_reg) begin
										rd_next = RD_DISC;
									end else if (!sh_reg[0]) begin
										op_next = OP_MODE;
									end
								end
								OP_MODE: begin
									mode_next = 1'b1;
									op_next   = OP_IGNORE;
									if (sh_reg == RHIP_BANK_PFX) begin
										bank_next = 1'b1;
										op_next   = OP_MODE;
									end else begin
										case (sh_reg[RHIP_MODE_HI:RHIP_MODE_LO])
											RHIP_M_WREG: begin
												wa_next = sh_reg[5:0];
												op_next = OP_WREG;
											end
											RHIP_M_RREG: begin
												ra_next = sh_reg[5:0];
												rd_next = RD_REG;
											end
											RHIP_M_MEM: begin
												case (sh_reg[5:0])
													RHIP_SUB_FIFO_LD: op_next = OP_FIFO;
													RHIP_SUB_FIFO_RD: rd_next = RD_FIFO;
													RHIP_SUB_PTM_A: begin
														pa_next = RHIP_PTM_A_BASE;
														op_next = OP_PTM;
													end
													RHIP_SUB_PTM_F: begin
														pa_next = RHIP_PTM_F_BASE;
														op_next = OP_PTM;
													end
													RHIP_SUB_PTM_TSN: begin
														pa_next = RHIP_PTM_T_BASE;
														op_next = OP_PTM;
													end
													default: op_next = OP_IGNORE;
												endcase
											end
											default: begin
												cs_next = 1'b1;
												cc_next = sh_reg[5:0];
												if (sh_reg[5:0] == RHIP_CMD_TRANSP) begin
													tp_pend_next = 1'b1;
												end else if (!rhip_cmd_timed(sh_reg[5:0])) begin
													op_next = OP_MODE;
												end
											end
										endcase
									end
								end
								OP_WREG: begin
									wr_next = 1'b1;
									wb_next = '{bank_b: bank_reg, addr: wa_reg, data: sh_reg};
									wa_next = wa_reg + 6'h01;
								end
								OP_FIFO: begin
									push_next = 1'b1;
									pd_next   = sh_reg;
								end
								OP_PTM: begin
									pw_next = 1'b1;
									pb_next = '{addr: pa_reg, data: sh_reg};
									pa_next = pa_reg + 7'h01;
								end
								default: ;
							endcase
						end
					end
					// end of acknowledge slot: release, or start a read byte
					LK_RX_ACK: begin
						if (scl_fall) begin
							pull_next = 1'b0;
							cnt_next  = '0;
							lk_next   = LK_RX;
							if (tp_pend_reg) begin
								tp_pend_next = 1'b0;
								tp_next      = 1'b1;
								lk_next      = LK_IDLE;
							end else if (rw_reg) begin
								lk_next  = LK_TX;
								cnt_next = 4'h1;
								case (rd_reg)
									RD_DISC: begin
										sh_next = RHIP_DISC_BYTE;
										ra_next = RHIP_DISC_START;
										rd_next = RD_REG;
									end
									RD_REG: begin
										sh_next = reg_rd_exists ? reg_rd_data : 8'h00;
										ra_next = ra_reg + 6'h01;
									end
									RD_FIFO: begin
										sh_next  = fifo_rd_data;
										pop_next = 1'b1;
									end
									default: sh_next = 8'h00;
								endcase
								pull_next = ~sh_next[7];
							end
						end
					end
					// shift out on falling clock, msb first
					LK_TX: begin
						if (scl_fall) begin
							if (cnt_reg == RHIP_BYTE_BITS) begin
								pull_next = 1'b0;
								lk_next   = LK_TX_ACK;
							end else begin
								sh_next   = {sh_reg[6:0], 1'b0};
								pull_next = ~sh_reg[6];
								cnt_next  = cnt_reg + 4'h1;
							end
						end
					end
					// host ack means another byte; nack leaves the line free
					LK_TX_ACK: begin
						if (scl_rise) begin
							lk_next = sda_s ? LK_IDLE : LK_RX_ACK;
						end
					end
					default: lk_next = LK_IDLE;
				endcase
			end
		end
	end

	// registers only
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lk_reg      <= LK_IDLE;
			op_reg      <= OP_ADDR;
			rd_reg      <= RD_NONE;
			sh_reg      <= '0;
			cnt_reg     <= '0;
			pull_reg    <= 1'b0;
			rw_reg      <= 1'b0;
			mode_reg    <= 1'b0;
			bank_reg    <= 1'b0;
			wa_reg      <= '0;
			ra_reg      <= '0;
			pa_reg      <= '0;
			tp_pend_reg <= 1'b0;
			tp_reg      <= 1'b0;
			tp_sel_reg  <= 1'b0;
			irq_reg     <= 1'b0;
			scl_q       <= 1'b1;
			sda_q       <= 1'b1;
			wr_reg      <= 1'b0;
			wb_reg      <= '0;
			push_reg    <= 1'b0;
			pd_reg      <= '0;
			pop_reg     <= 1'b0;
			pw_reg      <= 1'b0;
			pb_reg      <= '0;
			cs_reg      <= 1'b0;
			cc_reg      <= '0;
		end else begin
			lk_reg      <= lk_next;
			op_reg      <= op_next;
			rd_reg      <= rd_next;
			sh_reg      <= sh_next;
			cnt_reg     <= cnt_next;
			pull_reg    <= pull_next;
			rw_reg      <= rw_next;
			mode_reg    <= mode_next;
			bank_reg    <= bank_next;
			wa_reg      <= wa_next;
			ra_reg      <= ra_next;
			pa_reg      <= pa_next;
			tp_pend_reg <= tp_pend_next;
			tp_reg      <= tp_next;
			tp_sel_reg  <= tp_sel_next;
			irq_reg     <= irq_next;
			scl_q       <= scl_q_next;
			sda_q       <= sda_q_next;
			wr_reg      <= wr_next;
			wb_reg      <= wb_next;
			push_reg    <= push_next;
			pd_reg      <= pd_next;
			pop_reg     <= pop_next;
			pw_reg      <= pw_next;
			pb_reg      <= pb_next;
			cs_reg      <= cs_next;
			cc_reg      <= cc_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// command busy tracking and completion event
	rhip_cmd_exec u_exec (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.ce        (ce),
		.cmd_start (cs_reg),
		.cmd_code  (cc_reg),
		.cmd_done  (cmd_done),
		.busy      (cmd_busy),
		.done_evt  (done_evt)
	);

	// open-drain: only ever drives low, enable low while pulling
	assign sda_out        = 1'b0;
	assign sda_oe_n       = ~pull_reg;
	assign irq            = irq_reg;
	assign reg_wr         = wr_reg;
	assign reg_wr_bus     = wb_reg;
	assign reg_rd_addr    = ra_reg;
	assign reg_rd_bank_b  = bank_reg;
	assign fifo_push      = push_reg;
	assign fifo_push_data = pd_reg;
	assign fifo_pop       = pop_reg;
	assign ptm_wr         = pw_reg;
	assign ptm_wr_bus     = pb_reg;
	assign cmd_strobe     = cs_reg;
	assign cmd_code       = cc_reg;
	assign transparent    = tp_reg;

endmodule

// ==== test/rhip_i2c_monitor.sv ====
// checker on the ports of the i2c target port
// assumes one clk_sys domain with synchronous active-high rst
`timescale 1ns/1ps
module rhip_i2c_monitor
	import rhip_pkg::*;
(
	input wire logic      clk_sys,
	input wire logic      rst,
	input wire logic      ce,
	input wire logic      scl_in,
	input wire logic      sda_in,
	input wire logic      target_select_n,
	input wire logic      sda_oe_n,
	input wire logic      irq,
	input wire logic      reg_wr,
	input wire rhip_wr_t  reg_wr_bus,
	input wire logic      fifo_pop,
	input wire logic      ptm_wr,
	input wire rhip_ptm_t ptm_wr_bus,
	input wire logic      cmd_strobe,
	input wire logic [5:0] cmd_code,
	input wire logic      cmd_done,
	input wire logic      cmd_busy,
	input wire logic      transparent
);
	logic [1:0] pin_reg, pin_next; // last raw scl, sda
	logic [3:0] age_reg, age_next; // cycles since a raw start
	logic       wv_reg, wv_next;   // a write was seen in this transfer
	logic       pv_reg, pv_next;   // a memory write was seen
	logic [5:0] wa_reg, wa_next;
	logic [6:0] pa_reg, pa_next;
	logic       st;
	////////////////////////////////////////////////////////////////////////
	// raw pins are enough here; the design's own sync only adds delay
	always_comb begin
		st = pin_reg[1] & scl_in & pin_reg[0] & ~sda_in;
		pin_next = {scl_in, sda_in};
		age_next = st ? 4'h0 : age_reg + {3'h0, age_reg != 4'hf};
		wv_next = ~st & (wv_reg | reg_wr);
		wa_next = reg_wr ? reg_wr_bus.addr : wa_reg;
		pv_next = ~st & (pv_reg | ptm_wr);
		pa_next = ptm_wr ? ptm_wr_bus.addr : pa_reg;
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pin_reg <= 2'h3;
			age_reg <= 4'hf;
			wv_reg <= 1'b0;
			pv_reg <= 1'b0;
		end else begin
			pin_reg <= pin_next;
			age_reg <= age_next;
			wv_reg <= wv_next;
			pv_reg <= pv_next;
		end
		wa_reg <= wa_next;
		pa_reg <= pa_next;
	end
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	reset_quiet_a: assert property ($past(rst) |-> sda_oe_n && !irq && !cmd_busy && !transparent)
		else $error("outputs not quiet after reset");
	wr_step_a: assert property (reg_wr && wv_reg |-> reg_wr_bus.addr == wa_reg + 6'h01)
		else $error("register address did not step");
	ptm_step_a: assert property (ptm_wr && pv_reg |-> ptm_wr_bus.addr == pa_reg + 7'h01)
		else $error("memory address did not step");
	pop_single_a: assert property (fifo_pop |=> !fifo_pop [*8])
		else $error("fifo popped twice for one byte");
	busy_irq_a: assert property (ce && cmd_busy && cmd_done |-> ##[1:3] irq)
		else $error("no interrupt after command end");
	timed_busy_a: assert property (cmd_strobe && rhip_cmd_timed(cmd_code) |-> ##[0:2] cmd_busy)
		else $error("timed command not busy");
	irq_clear_a: assert property ($fell(irq) && !$past(rst) |-> age_reg < 4'h8)
		else $error("interrupt dropped without start");
	trans_hold_a: assert property (target_select_n [*5] ##0 transparent |=> transparent)
		else $error("transparent left with select high");
	trans_exit_a: assert property ((!target_select_n) [*4] ##0 transparent ##1
		($rose(scl_in) && !target_select_n) |-> ##[1:8] !transparent)
		else $error("transparent not left");
endmodule

bind rhip_i2c_port rhip_i2c_monitor mon (.*);

// ==== test/rhip_host_model.sv ====
// host bus controller model: drives clock, data and select by delays
// assumes the bench resolves the open-drain data wire into sda_i
`timescale 1ns/1ps
module rhip_host_model (
	output logic      scl_o,
	output logic      sda_o,
	output logic      sel_n,
	input  wire logic sda_i
);
	// clock and data idle high, select starts low; the clock stands still between frames
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		sel_n = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// data moves 80 ns after the fall, once the target let go of its ack
	task automatic bit_x(input logic b, output logic r);
		#80 sda_o = b;
		#40 scl_o = 1'b1;
		#20 r = sda_i;
		#20 scl_o = 1'b0;
	endtask
	task automatic start();
		#80 sda_o = 1'b1;
		#40 scl_o = 1'b1;
		#40 sda_o = 1'b0;
		#40 scl_o = 1'b0;
	endtask
	task automatic stop();
		#80 sda_o = 1'b0;
		#40 scl_o = 1'b1;
		#40 sda_o = 1'b1;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, ack); // released so the target can pull low
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
		bit_x(last, r); // nack on the last byte ends the read
	endtask
	task automatic select(input logic v);
		sel_n = v;
	endtask
	task automatic pulse();
		#80 scl_o = 1'b0;
		#80 scl_o = 1'b1;
	endtask
endmodule

// ==== test/tb_reader_host_i2c_port.sv ====
// self-checking bench for the i2c target port
// assumes the host model, a register file and a fifo head model beside it
`timescale 1ns/1ps
module tb_reader_host_i2c_port;
	import rhip_pkg::*;
	localparam logic [5:0] LAST = 6'h30; // first missing register
	localparam logic [5:0] PSUB [4] = '{RHIP_SUB_FIFO_LD, RHIP_SUB_PTM_A, RHIP_SUB_PTM_F, RHIP_SUB_PTM_TSN};
	localparam logic [6:0] PBASE [4] = '{7'h00, RHIP_PTM_A_BASE, RHIP_PTM_F_BASE, RHIP_PTM_T_BASE};
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic cmd_done = 1'b0;
	logic [7:0] fifo_rd_data = 8'h30;
	logic scl_in, sda_h, sda_in, target_select_n, reg_rd_exists;
	logic sda_out, sda_oe_n, irq, reg_wr, reg_rd_bank_b, fifo_push, fifo_pop, ptm_wr, cmd_strobe;
	logic cmd_busy, transparent;
	logic [5:0] reg_rd_addr, cmd_code;
	logic [7:0] reg_rd_data, fifo_push_data;
	rhip_wr_t reg_wr_bus;
	rhip_ptm_t ptm_wr_bus;
	logic [14:0] wq[$], pq[$];
	logic [7:0] fq[$];
	logic [5:0] cq[$];
	int n_fail = 0;
	int n_tests = 0;
	always #10 clk_sys = ~clk_sys;
	rhip_i2c_port uut (.*);
	rhip_host_model host (.scl_o(scl_in), .sda_o(sda_h), .sel_n(target_select_n), .sda_i(sda_in));
	assign sda_in = sda_h & (sda_oe_n | sda_out); // open-drain wire
	function automatic logic [7:0] rv(input logic b, input logic [5:0] a);
		return {b, 1'b0, a} ^ 8'h5a; // content tied to bank and address
	endfunction
	function automatic logic [7:0] ex(input logic b, input logic [5:0] a);
		return (a < LAST) ? rv(b, a) : 8'h00;
	endfunction
	assign reg_rd_data = rv(reg_rd_bank_b, reg_rd_addr);
	assign reg_rd_exists = reg_rd_addr < LAST;
	// log every strobe the port gives; the fifo head steps on each pop
	always @(posedge clk_sys) begin
		if (reg_wr) wq.push_back(reg_wr_bus);
		if (ptm_wr) pq.push_back(ptm_wr_bus);
		if (fifo_push) fq.push_back(fifo_push_data);
		if (cmd_strobe) cq.push_back(cmd_code);
		if (fifo_pop) fifo_rd_data <= fifo_rd_data + 8'h01;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic end_sim();
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic send(input logic [7:0] q[$]);
		logic a;
		host.start();
		host.wbyte(8'ha0, a);
		chk(a, 16'h0);
		foreach (q[i]) begin
			host.wbyte(q[i], a);
			chk(a, 16'h0);
		end
	endtask
	task automatic rcv(input logic [7:0] e[$]);
		logic a;
		logic [7:0] d;
		host.start();
		host.wbyte(8'ha1, a);
		chk(a, 16'h0);
		foreach (e[i]) begin
			host.rbyte(i == e.size() - 1, d);
			chk(d, e[i]);
		end
		host.stop();
	endtask
	task automatic settle();
		host.stop();
		repeat (8) @(negedge clk_sys);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		logic a;
		logic [5:0] ad;
		logic [7:0] h, m;
		logic [7:0] dq[$];
		void'($urandom(33192));
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (4) @(negedge clk_sys);
		rcv({8'hff, ex(1'b0, 6'h01), ex(1'b0, 6'h02)});
		host.start();
		host.wbyte({7'h50 ^ 7'($urandom_range(127, 1)), 1'b0}, a);
		chk(a, 16'h1);
		host.stop();
		// plain, wrapping, second bank, then bank forgotten after stop
		for (int k = 0; k < 4; k++) begin
			ad = (k == 1) ? 6'h3f : 6'($urandom);
			m = {RHIP_M_WREG, ad};
			dq = {8'($urandom), 8'($urandom), 8'($urandom)};
			wq.delete();
			if (k == 2) send({RHIP_BANK_PFX, m, dq});
			else send({m, dq});
			settle();
			foreach (dq[i]) chk(wq[i], {k == 2, ad + 6'(i), dq[i]});
		end
		for (int k = 0; k < 2; k++) begin
			ad = k ? 6'($urandom) : 6'h2e;
			m = {RHIP_M_RREG, ad};
			if (k == 1) send({RHIP_BANK_PFX, m});
			else send({m});
			rcv({ex(k[0], ad), ex(k[0], ad + 6'h01), ex(k[0], ad + 6'h02)});
		end
		// fifo load, then the three memory regions, kept within size
		for (int j = 0; j < 4; j++) begin
			m = {RHIP_M_MEM, PSUB[j]};
			dq = {8'($urandom), 8'($urandom)};
			fq.delete();
			pq.delete();
			send({m, dq});
			settle();
			foreach (dq[i]) begin
				if (j == 0) chk(fq[i], dq[i]);
				else chk(pq[i], {PBASE[j] + 7'(i), dq[i]});
			end
		end
		h = fifo_rd_data;
		m = {RHIP_M_MEM, RHIP_SUB_FIFO_RD};
		send({m});
		rcv({h, h + 8'h01, h + 8'h02});
		cq.delete();
		wq.delete();
		m = {RHIP_M_WREG, 6'h05};
		h = 8'($urandom);
		send({8'hc2, m, h});
		settle();
		chk(cq[0], 16'h02);
		chk(wq[0], {1'b0, 6'h05, h});
		// timed command: no access until the interrupt comes
		send({8'hc8});
		settle();
		chk({cmd_busy, irq}, 16'h2);
		// a completion while the enable is low must be lost
		@(posedge clk_sys) begin
			ce <= 1'b0;
			cmd_done <= 1'b1;
		end
		@(posedge clk_sys) cmd_done <= 1'b0;
		@(posedge clk_sys) ce <= 1'b1;
		repeat (4) @(negedge clk_sys);
		chk({cmd_busy, irq}, 16'h2);
		@(posedge clk_sys) cmd_done <= 1'b1;
		@(posedge clk_sys) cmd_done <= 1'b0;
		repeat (6) @(negedge clk_sys);
		chk({cmd_busy, irq}, 16'h1);
		host.start();
		host.wbyte(8'ha0, a);
		host.stop();
		chk(a, 16'h0);
		chk(irq, 16'h0);
		host.select(1'b1);
		send({8'hdc});
		host.stop();
		host.pulse();
		repeat (8) @(negedge clk_sys);
		chk(transparent, 16'h1);
		host.select(1'b0);
		host.pulse();
		repeat (8) @(negedge clk_sys);
		chk(transparent, 16'h0);
		rcv({8'hff, ex(1'b0, 6'h01)});
		end_sim();
	end
	// about seventy bytes at 1.5 us each; one millisecond is ample
	initial begin
		#1000000;
		n_fail++;
		end_sim();
	end
endmodule
